/* File: src/phy_mii_end.sv */
// transceiver end of the mac-side link
// Functional notes
// (RULE_01) mac drives 4 tx bits, rmii 2
// (RULE_02) mac enable high exactly while data valid
// (RULE_03) mii tx clock: fast or slow rate
// (RULE_04) receive error flags invalid medium symbols
// (RULE_05) rx data 4 bits, rmii low two
// (RULE_06) rx valid with data; rmii carrier-valid
// (RULE_07) continuous rx clock times rx outputs
// (RULE_08) collision held for whole collision
// (RULE_09) collision async, off in full duplex
// (RULE_10) half duplex: carrier on tx or rx
// (RULE_11) full duplex: carrier on rx only
// (RULE_12) station clocks management at most 2.5MHz
// (RULE_13) reset needs one management clock transition
// (RULE_14) bidirectional management data line
// (RULE_15) reference clock from crystal or oscillator
// (RULE_16) rmii uses 50MHz reference clock; here refClk50 copies the link clock, 5MHz fast or 1MHz slow
// (RULE_17) reset held 1ms, then edge completes
// (RULE_18) rmii two bits per reference rise
// (RULE_19) open-drain active-low management interrupt
`timescale 1ns/1ns
module phy_mii_end (
    // system
    input wire logic clk_sys, // crystal or oscillator reference; see (RULE_15)
    input wire logic arst_n,
    // link
    phy_mii_if.phy link,
    // medium side
    input wire logic [3:0] mediumRxData,
    input wire logic mediumRxActive,
    input wire logic mediumSymbolBad,
    input wire logic mediumCollision,
    // configuration
    input wire logic speed100,
    input wire logic rmiiMode,
    input wire logic [15:0] basic_control_register,
    input wire logic mgmtEvent,
    // to the user
    output logic [3:0] txCaptured,
    output logic txCapturedValid,
    output logic resetDone
);
    typedef enum {RST_HOLD, RST_WAIT_MDC, RST_DONE} rst_state_t;
    rst_state_t rstState;
    typedef logic [phy_mii_pkg::DIV_W-1:0] div_count_t; // divider compare width
    logic [phy_mii_pkg::DIV_W-1:0] divCount; // link clock divider
    logic linkClk; // generated tx/rx clock
    logic [phy_mii_pkg::RST_W-1:0] rstCount; // reset hold counter
    logic [2:0] mdcSync; // management clock synchroniser
    logic [2:0] refSync; // rmii reference synchroniser
    logic [1:0] txEnSync; // sampled mac enable
    logic [3:0] txSync1, txSync2; // sampled mac data
    logic [1:0] mdioSync; // sampled management data
    logic fullDuplex;
    logic sampleEdge;
    assign fullDuplex = basic_control_register[phy_mii_pkg::DUPLEX_BIT];

    // free-running divider for the mii clocks; stops only in reset
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            divCount <= '0;
            linkClk <= 1'b0;
        end
        else if (divCount >= (speed100 ? div_count_t'(phy_mii_pkg::CLK_HALF_100 - 1)
                                       : div_count_t'(phy_mii_pkg::CLK_HALF_10 - 1)))
        begin
            divCount <= '0;
            linkClk <= !linkClk; // see (RULE_03) see (RULE_07)
        end
        else
            divCount <= divCount + 1'b1;
    end
    assign link.txClk = linkClk;
    assign link.rxClk = linkClk;

    // synchronisers for every pin coming from the mac side except mdioStaOe, which is used unsynchronised
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            mdcSync <= '0;
            refSync <= '0;
            txEnSync <= '0;
            txSync1 <= '0;
            txSync2 <= '0;
            mdioSync <= 2'b11;
        end
        else
        begin
            mdcSync <= {mdcSync[1:0], link.mgmtClk};
            refSync <= {refSync[1:0], link.refClk50};
            txEnSync <= {txEnSync[0], link.txEnable};
            txSync1 <= link.txData;
            txSync2 <= txSync1;
            mdioSync <= {mdioSync[0], link.mdioLine};
        end
    end

    // sampling edge: rising mii clock, or rising synced rmii reference
    assign sampleEdge = rmiiMode ? (refSync[1] && !refSync[2]) // see (RULE_16) see (RULE_18)
                                 : (divCount == '0 && linkClk);

    // capture mac data while enable stands; rmii keeps only two bits
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            txCaptured <= '0;
            txCapturedValid <= 1'b0;
        end
        else
        begin
            txCapturedValid <= sampleEdge && txEnSync[1]; // see (RULE_02)
            if (sampleEdge && txEnSync[1])
                txCaptured <= rmiiMode ? {2'b00, txSync2[1:0]} : txSync2; // see (RULE_01)
        end
    end

    // receive outputs change on the driving edge
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            link.rxData <= '0;
            link.rxValid <= 1'b0;
            link.rxError <= 1'b0;
        end
        else if (sampleEdge)
        begin
            link.rxData <= rmiiMode ? {2'b00, mediumRxData[1:0]} : mediumRxData; // see (RULE_05)
            link.rxValid <= mediumRxActive; // see (RULE_06)
            link.rxError <= mediumRxActive && mediumSymbolBad; // see (RULE_04)
        end
    end

    // collision and carrier follow the medium on every sys edge, not the mii clock
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            link.collision <= 1'b0;
            link.carrierSense <= 1'b0;
        end
        else
        begin
            link.collision <= !fullDuplex && mediumCollision; // see (RULE_08) see (RULE_09)
            if (fullDuplex)
                link.carrierSense <= mediumRxActive; // see (RULE_11)
            else
                link.carrierSense <= mediumRxActive || txEnSync[1]; // see (RULE_10)
        end
    end

    // reset sequence: hold time, then wait for one management clock change
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rstState <= RST_HOLD;
            rstCount <= '0;
            resetDone <= 1'b0;
        end
        else
        begin
            case (rstState)
                RST_HOLD:
                begin
                    rstCount <= rstCount + 1'b1;
                    if (rstCount == phy_mii_pkg::RST_W'(phy_mii_pkg::RESET_CYCLES - 1))
                        rstState <= RST_WAIT_MDC; // see (RULE_17)
                end
                RST_WAIT_MDC:
                    if (mdcSync[2] != mdcSync[1])
                    begin
                        rstState <= RST_DONE; // see (RULE_13)
                        resetDone <= 1'b1;
                    end
                RST_DONE:
                    resetDone <= 1'b1;
                default:
                    rstState <= RST_HOLD;
            endcase
        end
    end

    // management data: echo the last sampled bit back when the station releases the line
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            link.mdioFromPhy <= 1'b1;
            link.mdioPhyOe <= 1'b0;
            link.mgmtIntOe <= 1'b0;
        end
        else
        begin
            if (mdcSync[1] && !mdcSync[2])
                link.mdioFromPhy <= mdioSync[1]; // see (RULE_14)
            link.mdioPhyOe <= resetDone && !link.mdioStaOe; // see (RULE_14)
            link.mgmtIntOe <= resetDone && mgmtEvent; // see (RULE_19)
        end
    end
endmodule

/* File: src/phy_mii_pkg.sv */
// shared constants for the transceiver mac-side link
package phy_mii_pkg;
    // clock rate of both ends, in hertz
    localparam int SYS_HZ = 10_000_000;
    // link clock half periods in sys cycles (10 MHz cannot make 25 MHz, so the divider is scaled down)
    localparam int CLK_HALF_100 = 1;
    localparam int CLK_HALF_10 = 5;
    // management clock limit and the derived half period for the station
    localparam int MGMT_MAX_HZ = 2_500_000;
    localparam int MGMT_HALF = (SYS_HZ + 2 * MGMT_MAX_HZ - 1) / (2 * MGMT_MAX_HZ);
    // least reset hold, in microseconds, and its cycle count
    localparam int RESET_MIN_US = 1000;
    localparam int RESET_CYCLES = (RESET_MIN_US * (SYS_HZ / 1_000_000));
    // bit of the basic control register that selects full duplex
    localparam int DUPLEX_BIT = 8;
    // divider and counter widths
    localparam int DIV_W = 4;
    localparam int RST_W = 14;
endpackage

/* File: src/phy_mii_if.sv */
// pins between the transceiver and the mac / management station
`timescale 1ns/1ns
interface phy_mii_if;
    logic [3:0] txData;
    logic txEnable;
    logic txClk;
    logic rxClk;
    logic [3:0] rxData;
    logic rxValid;
    logic rxError;
    logic collision;
    logic carrierSense;
    logic mgmtClk;
    logic mdioFromPhy;
    logic mdioPhyOe;
    logic mdioFromSta;
    logic mdioStaOe;
    logic mgmtIntOe;
    logic refClk50;
    // resolved pulled-up lines
    wire mdioLine = mdioPhyOe ? mdioFromPhy : (mdioStaOe ? mdioFromSta : 1'b1);
    wire mgmt_interrupt_out = mgmtIntOe ? 1'b0 : 1'b1;
    modport phy (input txData, txEnable, mgmtClk, mdioLine, mdioFromSta, mdioStaOe, refClk50,
                 output txClk, rxClk, rxData, rxValid, rxError, collision, carrierSense,
                 mdioFromPhy, mdioPhyOe, mgmtIntOe);
    modport mac (output txData, txEnable, mgmtClk, mdioFromSta, mdioStaOe, refClk50,
                 input txClk, rxClk, rxData, rxValid, rxError, collision, carrierSense,
                 mdioLine, mgmt_interrupt_out, mdioFromPhy, mdioPhyOe, mgmtIntOe);
endinterface

/* File: src/mac_mii_end.sv */
// mac and management station end of the link
`timescale 1ns/1ns
module mac_mii_end (
    // system
    input wire logic clk_sys,
    input wire logic arst_n,
    // link
    phy_mii_if.mac link,
    // user transmit
    input wire logic [3:0] userTxData,
    input wire logic userTxValid,
    input wire logic rmiiMode,
    // user receive
    output logic [3:0] userRxData,
    output logic userRxValid,
    output logic userRxError,
    // management
    input wire logic mgmtWrite,
    input wire logic mgmtWriteBit
);
    logic [2:0] clkSync; // synchronised phy tx clock
    logic [phy_mii_pkg::DIV_W-1:0] mdcCount; // management clock divider
    logic [3:0] rxSync1, rxSync2;
    logic [2:0] rxCtlSync1, rxCtlSync2; // valid, error, spare
    logic txEdge;

    // synchronise clock and receive pins before use
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            clkSync <= '0;
            rxSync1 <= '0;
            rxSync2 <= '0;
            rxCtlSync1 <= '0;
            rxCtlSync2 <= '0;
        end
        else
        begin
            clkSync <= {clkSync[1:0], link.txClk};
            rxSync1 <= link.rxData;
            rxSync2 <= rxSync1;
            rxCtlSync1 <= {1'b0, link.rxError, link.rxValid};
            rxCtlSync2 <= rxCtlSync1;
        end
    end
    assign txEdge = clkSync[1] && !clkSync[2];

    // drive data and enable together on the rising tx clock
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            link.txData <= '0;
            link.txEnable <= 1'b0;
            link.refClk50 <= 1'b0;
        end
        else
        begin
            link.refClk50 <= clkSync[1]; // see (RULE_16)
            if (txEdge)
            begin
                link.txEnable <= userTxValid; // see (RULE_02)
                link.txData <= rmiiMode ? {2'b00, userTxData[1:0]} : userTxData; // see (RULE_01) see (RULE_18)
            end
        end
    end

    // receive capture on the rising edge
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            userRxData <= '0;
            userRxValid <= 1'b0;
            userRxError <= 1'b0;
        end
        else
        begin
            userRxValid <= txEdge && rxCtlSync2[0];
            userRxError <= txEdge && rxCtlSync2[1];
            if (txEdge)
                userRxData <= rmiiMode ? {2'b00, rxSync2[1:0]} : rxSync2; // see (RULE_18)
        end
    end

    // management clock runs free at no more than the limit, giving the reset its transition
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            mdcCount <= '0;
            link.mgmtClk <= 1'b0;
            link.mdioStaOe <= 1'b0;
            link.mdioFromSta <= 1'b1;
        end
        else
        begin
            if (mdcCount == phy_mii_pkg::DIV_W'(phy_mii_pkg::MGMT_HALF - 1))
            begin
                mdcCount <= '0;
                link.mgmtClk <= !link.mgmtClk; // see (RULE_12) see (RULE_13)
            end
            else
                mdcCount <= mdcCount + 1'b1;
            link.mdioStaOe <= mgmtWrite;
            link.mdioFromSta <= mgmtWriteBit;
        end
    end
endmodule

/* File: sim/phy_mii_assertions.sv */
// timing checks on the link between the two ends
`timescale 1ns/1ns
module phy_mii_assertions (
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // link
    input wire logic txClk,
    input wire logic rxClk,
    input wire logic collision,
    input wire logic carrierSense,
    input wire logic mgmtClk,
    input wire logic mgmtIntOe,
    // transceiver side
    input wire logic [15:0] basic_control_register,
    input wire logic mediumRxActive,
    input wire logic mediumCollision,
    input wire logic speed100,
    input wire logic mgmtEvent,
    input wire logic resetDone
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    logic fd; // full duplex selected
    logic [13:0] rstCnt; // cycles since reset release, saturating
    logic [3:0] mdcAge; // cycles since the last management clock change
    logic mdcOld; // management clock one cycle ago
    assign fd = basic_control_register[phy_mii_pkg::DUPLEX_BIT];
    // saturate so a long run never wraps back below the reset figure
    always_ff @(posedge clk_sys or negedge arst_n)
        if (!arst_n)
            rstCnt <= 14'h0;
        else if (rstCnt != 14'h3FFF)
            rstCnt <= rstCnt + 14'h1;
    // age of the last management clock change
    always_ff @(posedge clk_sys or negedge arst_n)
        if (!arst_n)
        begin
            mdcOld <= 1'b0;
            mdcAge <= 4'hF;
        end
        else
        begin
            mdcOld <= mgmtClk;
            mdcAge <= (mgmtClk != mdcOld) ? 4'h0 : ((mdcAge == 4'hF) ? mdcAge : mdcAge + 4'h1);
        end
    // slow link clock: high for five cycles, then low
    sequence slowHigh;
        txClk[*5] ##1 !txClk;
    endsequence
    AST_COL_FD: assert property (fd && $past(fd) |-> !collision) else $error("collision in full duplex");
    AST_COL_HD: assert property (!fd && !$past(fd) |-> collision == $past(mediumCollision))
        else $error("collision does not follow medium");
    AST_CRS_FD: assert property (fd && $past(fd) |-> carrierSense == $past(mediumRxActive))
        else $error("carrier wrong in full duplex");
    AST_CRS_HD: assert property (!fd && !$past(fd) && $past(mediumRxActive) |-> carrierSense)
        else $error("carrier missing in half duplex");
    AST_TXCLK_FAST: assert property (speed100 && rstCnt > 14'h2 |-> txClk != $past(txClk))
        else $error("fast tx clock stalled");
    AST_RXCLK_FAST: assert property (speed100 && rstCnt > 14'h2 |-> rxClk != $past(rxClk))
        else $error("fast rx clock stalled");
    AST_TXCLK_SLOW: assert property (!speed100 && $rose(txClk) |-> slowHigh)
        else $error("slow tx clock half period wrong");
    AST_MGMT_INTERRUPT_OUT_SET: assert property ($rose(mgmtEvent) |-> ##[1:4] mgmtIntOe) else $error("interrupt not raised");
    AST_MGMT_INTERRUPT_OUT_CLR: assert property (!mgmtEvent[*4] |-> !mgmtIntOe) else $error("interrupt without event");
    AST_RST_MIN: assert property ($rose(resetDone) |-> rstCnt >= 14'h2710) else $error("reset done too early");
    AST_RST_MDC: assert property ($rose(resetDone) |-> mdcAge <= 4'h8) else $error("reset done without clock");
endmodule

/* File: sim/tb.sv */
// self-checking bench joining both ends of the link
`timescale 1ns/1ns
module tb;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic [3:0] mediumRxData = 4'h0;
    logic mediumRxActive = 1'b0, mediumSymbolBad = 1'b0, mediumCollision = 1'b0;
    logic speed100 = 1'b1, mgmtEvent = 1'b0, userTxValid = 1'b0, mgmtWrite = 1'b0, mgmtWriteBit = 1'b0;
    logic [15:0] basic_control_register = 16'h0100; // full duplex
    logic [3:0] userTxData = 4'h0;
    logic rmii = 1'b0; // reduced-pin mode on both ends
    logic [3:0] txCaptured, userRxData;
    logic txCapturedValid, resetDone, userRxValid, userRxError;
    int error_cnt = 0, checked = 0, cycles = 0, seed = 26745;
    logic [4:0] txQ[$], rxQ[$]; // expected nibbles, error flag on top
    always #50 clk_sys = ~clk_sys;
    phy_mii_if link();
    phy_mii_end i_phy_mii_end (.clk_sys(clk_sys), .arst_n(arst_n), .link(link), .mediumRxData(mediumRxData),
        .mediumRxActive(mediumRxActive), .mediumSymbolBad(mediumSymbolBad), .mediumCollision(mediumCollision),
        .speed100(speed100), .rmiiMode(rmii), .basic_control_register(basic_control_register),
        .mgmtEvent(mgmtEvent), .txCaptured(txCaptured), .txCapturedValid(txCapturedValid), .resetDone(resetDone));
    mac_mii_end i_mac_mii_end (.clk_sys(clk_sys), .arst_n(arst_n), .link(link), .userTxData(userTxData),
        .userTxValid(userTxValid), .rmiiMode(rmii), .userRxData(userRxData), .userRxValid(userRxValid),
        .userRxError(userRxError), .mgmtWrite(mgmtWrite), .mgmtWriteBit(mgmtWriteBit));
    phy_mii_assertions i_phy_mii_assertions (.clk_sys(clk_sys), .arst_n(arst_n), .txClk(link.txClk),
        .rxClk(link.rxClk), .collision(link.collision), .carrierSense(link.carrierSense), .mgmtClk(link.mgmtClk),
        .mgmtIntOe(link.mgmtIntOe), .basic_control_register(basic_control_register),
        .mediumRxActive(mediumRxActive), .mediumCollision(mediumCollision), .speed100(speed100),
        .mgmtEvent(mgmtEvent), .resetDone(resetDone));
    // one comparison, counted
    task automatic chk(input logic [4:0] seen, input logic [4:0] exp);
        checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("checked %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // bounded wait for reset completion
    task automatic waitDone();
        for (int i = 0; i < 10200 && resetDone !== 1'b1; i++)
            @(negedge clk_sys);
        chk({4'h0, resetDone}, 5'h01);
    endtask
    // one nibble each way per link clock period, then drain
    task automatic burst(input int n);
        repeat (n)
        begin
            @(posedge link.txClk);
            @(negedge clk_sys);
            userTxData = 4'($random(seed));
            userTxValid = 1'b1;
            txQ.push_back(rmii ? {3'b000, userTxData[1:0]} : {1'b0, userTxData});
            mediumRxData = 4'($random(seed));
            mediumSymbolBad = ($random(seed) & 3) == 0;
            mediumRxActive = 1'b1;
            rxQ.push_back({mediumSymbolBad, rmii ? {2'b00, mediumRxData[1:0]} : mediumRxData});
        end
        @(posedge link.txClk);
        @(negedge clk_sys);
        userTxValid = 1'b0;
        mediumRxActive = 1'b0;
        mediumSymbolBad = 1'b0;
        repeat (40) @(negedge clk_sys);
        chk(5'(txQ.size()), 5'h00);
        chk(5'(rxQ.size()), 5'h00);
    endtask
    // watcher: takes the oldest note whenever a result shows, and cuts a hang
    always @(negedge clk_sys)
    begin
        cycles++;
        if (cycles > 40000)
        begin
            error_cnt++;
            conclude();
        end
        else
        begin
            if (txCapturedValid === 1'b1)
                chk({1'b0, txCaptured}, txQ.size() > 0 ? txQ.pop_front() : 5'h1F);
            if (userRxValid === 1'b1 || userRxError === 1'b1)
                chk({userRxError, userRxData}, rxQ.size() > 0 ? rxQ.pop_front() : 5'h1F);
        end
    end
    initial
    begin
        repeat (4) @(negedge clk_sys);
        arst_n = 1'b1;
        waitDone();
        mediumCollision = 1'b1; // ignored in full duplex
        burst(12);
        chk({4'h0, link.collision}, 5'h00);
        $display("fast full duplex done");
        basic_control_register = 16'h0000;
        repeat (3) @(negedge clk_sys);
        chk({4'h0, link.collision}, 5'h01);
        mediumCollision = 1'b0;
        burst(6);
        $display("half duplex done");
        mgmtEvent = 1'b1;
        repeat (6) @(negedge clk_sys);
        chk({4'h0, link.mgmt_interrupt_out}, 5'h00);
        mgmtEvent = 1'b0;
        mgmtWrite = 1'b1;
        repeat (6) @(negedge clk_sys);
        chk({4'h0, link.mgmt_interrupt_out}, 5'h01);
        chk({4'h0, link.mdioLine}, 5'h00);
        mgmtWriteBit = 1'b1;
        repeat (6) @(negedge clk_sys);
        chk({4'h0, link.mdioLine}, 5'h01);
        mgmtWrite = 1'b0;
        $display("management done");
        arst_n = 1'b0; // second reset to change speed
        speed100 = 1'b0;
        basic_control_register = 16'h0100;
        repeat (4) @(negedge clk_sys);
        arst_n = 1'b1;
        waitDone();
        burst(8);
        $display("slow speed done");
        rmii = 1'b1; // only the low two bits cross the link now
        burst(8);
        $display("rmii done");
        conclude();
    end
endmodule
